// File: pkg/lpsc_pkg.sv
// Shared constants and carriers of the light/proximity sensor control block.
// Assumes a single 40 MHz system clock and an I2C host on the pins.
package lpsc_pkg;
	// Target address bytes (write / read form)
	localparam logic [7:0] ADDR_WR_BYTE = 8'h88;
	localparam logic [7:0] ADDR_RD_BYTE = 8'h89;

	// Register offsets
	localparam logic [7:0] REG_CONFIG     = 8'h01;
	localparam logic [7:0] REG_INTERRUPT  = 8'h02;
	localparam logic [7:0] REG_PROX_LOW   = 8'h03;
	localparam logic [7:0] REG_PROX_HIGH  = 8'h04;
	localparam logic [7:0] REG_LIGHT_TH1  = 8'h05;
	localparam logic [7:0] REG_LIGHT_TH2  = 8'h06;
	localparam logic [7:0] REG_LIGHT_TH3  = 8'h07;
	localparam logic [7:0] REG_PROX_DATA  = 8'h08;
	localparam logic [7:0] REG_LIGHT_DT1  = 8'h09;
	localparam logic [7:0] REG_LIGHT_DT2  = 8'h0a;
	localparam logic [7:0] REG_LIGHT_RNG  = 8'h0b;

	// Reset value shared by every writable register
	localparam logic [7:0] REG_RESET = 8'h00;

	// Persistence encodings and the run lengths they ask for
	localparam logic [4:0] PERSIST_RUN [0:3] = '{5'h01, 5'h04, 5'h08, 5'h10};

	// Light full-scale codes after decoding (800/400/200/100/50 lux)
	localparam logic [2:0] RANGE_50LUX = 3'h4;

	// Timing
	localparam int CLK_MHZ     = 40;
	localparam int T_MEAS_NS   = 540000;
	localparam int MEAS_CYC    = T_MEAS_NS * CLK_MHZ / 1000;
	// Sleep between prox pulses in microseconds, indexed by sleep code
	localparam int SLEEP_US [0:7] = '{800000, 400000, 200000, 100000,
		75000, 50000, 12500, 0};

	// Register 0x01 layout
	typedef struct packed {
		logic       prox_enable;
		logic [2:0] prox_sleep_select;
		logic       emitter_drive_select;
		logic       light_enable;
		logic [1:0] unused;
	} lpsc_cfg_t;

	// Register 0x02 layout
	typedef struct packed {
		logic       prox_event_flag;
		logic [1:0] prox_persistence;
		logic       unused;
		logic       light_event_flag;
		logic [1:0] light_persistence;
		logic       combine_and;
	} lpsc_int_t;

	// Proximity sequencer states
	typedef enum logic [1:0] {
		PX_OFF   = 2'b00,
		PX_MEAS  = 2'b01,
		PX_SLEEP = 2'b10
	} lpsc_px_t;

	// I2C target states
	typedef enum logic [2:0] {
		IC_IDLE = 3'b000,
		IC_ADDR = 3'b001,
		IC_AACK = 3'b010,
		IC_WR   = 3'b011,
		IC_WACK = 3'b100,
		IC_RD   = 3'b101,
		IC_RACK = 3'b110
	} lpsc_i2c_t;
endpackage

// File: hw/lpsc_top.sv
// Light/proximity sensor control: I2C target, register file, proximity
// sequencer, window comparison, persistence filters and interrupt pin.
// Assumes an analog front end that presents results on plain ports in the
// mclk_i domain, and an I2C host whose pins are asynchronous to mclk_i.
//
// Overview of operation
// - Upper light register shows result bits 11:8
// - Range code 100..111 all mean 50 lux
// - Answer address bytes 0x88 write, 0x89 read
// - Light results accepted only while enabled
// - Each prox measurement lasts about 0.54 ms
// - Drive bit selects 100 or 200 mA
// - Sleep interval separates prox measurements
// - Light outside 12-bit window is out-of-range
// - Prox outside 8-bit window is out-of-range
// - Flag only after persistence run, per channel; light code 00 flags every light result, in window or not
// - Raised interrupt holds until register 0x02 written
// - Combine bit: 0 OR, 1 AND
// - Both enables zero means power-down
// - Sleep code 111 continuous, 000 800 ms
// - Sticky flags bits 7, 3; write 0 clears
// - Persistence 00/01/10/11 gives 1/4/8/16 runs
// - Interrupt pin low while combined condition true
`timescale 1ns/1ps

// Run-length filter for one channel
module lpsc_persist (
	input  wire logic       mclk_i,     // System clock
	input  wire logic       reset_i,    // Synchronous reset
	input  wire logic       ce_i,       // Clock enable
	input  wire logic       stb_i,      // A new result is judged
	input  wire logic       out_i,      // Result lies outside the window
	input  wire logic [1:0] prst_i,     // Persistence code
	output logic            hit_o       // Run complete, raise the flag
);
	logic [4:0] run_r;                  // Consecutive out-of-range count
	logic [4:0] run_inc;                // Count including this result
	logic [4:0] need;                   // Run length asked for

	assign need    = lpsc_pkg::PERSIST_RUN[prst_i];
	assign run_inc = run_r + 5'h01;
	assign hit_o   = stb_i && out_i && (run_inc >= need);

	// Saturating run counter; any in-range result breaks the run
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			run_r <= 5'h00;
		end else if (ce_i && stb_i) begin
			if (!out_i) begin
				run_r <= 5'h00;
			end else if (run_r < 5'h10) begin
				run_r <= run_inc;
			end
		end
	end
endmodule

module lpsc_top #(
	parameter int MEAS_CYC   = lpsc_pkg::MEAS_CYC,  // Measurement length
	parameter int CYC_PER_US = lpsc_pkg::CLK_MHZ    // Scales sleep table
) (
	input  wire logic        mclk_i,              // System clock, 40 MHz
	input  wire logic        reset_i,             // Synchronous reset
	input  wire logic        ce_i,                // Clock enable
	input  wire logic        scl_i,               // I2C clock pin
	input  wire logic        sda_i,               // I2C data pin level
	output logic             sda_o,               // I2C data drive value
	output logic             sda_oe_o,            // High drives sda low
	input  wire logic [11:0] light_result_i,      // Light converter result
	input  wire logic        light_valid_i,       // Light result strobe
	input  wire logic [7:0]  prox_result_i,       // Prox converter result
	output logic             light_enable_o,      // Light sensing active
	output logic             prox_enable_o,       // Prox sensing active
	output logic             power_down_o,        // Both channels off
	output logic             emitter_drive_select_o, // 1: 200 mA pulses
	output logic             emitter_pulse_o,     // Prox measurement window
	output logic [2:0]       light_full_scale_code_o, // Decoded range
	output logic             irq_out_low_o        // Interrupt, active low
);
	// Pin synchronisers; stage one is read only by stage two
	logic [1:0] scl_sync_r, sda_sync_r;
	logic       scl_q_r, sda_q_r;                 // Previous synced level
	logic       scl_rise, scl_fall, i2c_start, i2c_stop;

	// I2C engine state
	lpsc_pkg::lpsc_i2c_t ic_r;
	logic [2:0] bit_r;                            // Bit counter
	logic       done_r;                           // Eight bits shifted in
	logic [7:0] sh_r;                             // Receive shift register
	logic [7:0] tx_r;                             // Transmit shift register
	logic       rw_r;                             // Read transfer
	logic       have_ptr_r;                       // Pointer byte received
	logic [7:0] ptr_r;                            // Register pointer
	logic       wr_stb_r;                         // One-cycle write pulse
	logic [7:0] wr_addr_r, wr_data_r;

	// Register file
	lpsc_pkg::lpsc_cfg_t cfg_r;
	lpsc_pkg::lpsc_int_t int_r;
	logic [7:0]  prox_low_r, prox_high_r, th1_r, th2_r, th3_r;
	logic [7:0]  prox_data_r;
	logic [11:0] light_data_r;
	logic [2:0]  range_r;
	logic [7:0]  rd_data;

	// Proximity sequencer
	lpsc_pkg::lpsc_px_t px_r;
	logic [24:0] px_cnt_r;
	logic [24:0] sleep_cyc;
	logic        px_done;

	// Comparison and filtering
	logic [11:0] light_low, light_high;
	logic        light_stb, light_out, light_hit;
	logic        prox_out, prox_hit;
	logic        wr_int, wr_cfg, irq_cond;

	// Edge and bus-condition detection on the synced levels
	assign scl_rise  = scl_sync_r[1] && !scl_q_r;
	assign scl_fall  = !scl_sync_r[1] && scl_q_r;
	assign i2c_start = scl_sync_r[1] && scl_q_r && sda_q_r && !sda_sync_r[1];
	assign i2c_stop  = scl_sync_r[1] && scl_q_r && !sda_q_r && sda_sync_r[1];
	assign sda_o     = 1'b0;                      // Open drain, low only

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			scl_sync_r <= 2'b11;
			sda_sync_r <= 2'b11;
			scl_q_r    <= 1'b1;
			sda_q_r    <= 1'b1;
		end else if (ce_i) begin
			scl_sync_r <= {scl_sync_r[0], scl_i};
			sda_sync_r <= {sda_sync_r[0], sda_i};
			scl_q_r    <= scl_sync_r[1];
			sda_q_r    <= sda_sync_r[1];
		end
	end

	// Read selection; unmapped and reserved addresses read zero
	always_comb begin
		unique case (ptr_r)
			lpsc_pkg::REG_CONFIG:    rd_data = cfg_r;
			lpsc_pkg::REG_INTERRUPT: rd_data = int_r;
			lpsc_pkg::REG_PROX_LOW:  rd_data = prox_low_r;
			lpsc_pkg::REG_PROX_HIGH: rd_data = prox_high_r;
			lpsc_pkg::REG_LIGHT_TH1: rd_data = th1_r;
			lpsc_pkg::REG_LIGHT_TH2: rd_data = th2_r;
			lpsc_pkg::REG_LIGHT_TH3: rd_data = th3_r;
			lpsc_pkg::REG_PROX_DATA: rd_data = prox_data_r;
			lpsc_pkg::REG_LIGHT_DT1: rd_data = light_data_r[7:0];
			lpsc_pkg::REG_LIGHT_DT2: rd_data = {4'h0, light_data_r[11:8]};
			lpsc_pkg::REG_LIGHT_RNG: rd_data = {5'h00, range_r};
			default:                 rd_data = 8'h00;
		endcase
	end

	// I2C target; sda changes only after scl falls
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			ic_r <= lpsc_pkg::IC_IDLE;
			bit_r <= 3'h0;
			done_r <= 1'b0;
			sh_r <= 8'h00;
			tx_r <= 8'h00;
			rw_r <= 1'b0;
			have_ptr_r <= 1'b0;
			ptr_r <= 8'h00;
			sda_oe_o <= 1'b0;
			wr_stb_r <= 1'b0;
			wr_addr_r <= 8'h00;
			wr_data_r <= 8'h00;
		end else if (ce_i) begin
			wr_stb_r <= 1'b0;
			if (i2c_start) begin                      // Start or repeat start
				ic_r <= lpsc_pkg::IC_ADDR;
				bit_r <= 3'h0;
				done_r <= 1'b0;
				sda_oe_o <= 1'b0;
			end else if (i2c_stop) begin
				ic_r <= lpsc_pkg::IC_IDLE;
				sda_oe_o <= 1'b0;
			end else if (scl_rise) begin
				if (ic_r == lpsc_pkg::IC_ADDR || ic_r == lpsc_pkg::IC_WR) begin
					sh_r <= {sh_r[6:0], sda_sync_r[1]};
					bit_r <= bit_r + 3'h1;
					done_r <= (bit_r == 3'h7);
				end else if (ic_r == lpsc_pkg::IC_RACK) begin
					done_r <= sda_sync_r[1];              // Host NACK seen
				end
			end else if (scl_fall) begin
				unique case (ic_r)
					lpsc_pkg::IC_IDLE: ;
					lpsc_pkg::IC_ADDR: if (done_r) begin
						done_r <= 1'b0;
						// Only our two address bytes are acknowledged
						if (sh_r[7:1] == lpsc_pkg::ADDR_WR_BYTE[7:1]) begin
							rw_r <= sh_r[0];
							have_ptr_r <= 1'b0;
							sda_oe_o <= 1'b1;
							ic_r <= lpsc_pkg::IC_AACK;
						end else begin
							ic_r <= lpsc_pkg::IC_IDLE;
						end
					end
					lpsc_pkg::IC_WR: if (done_r) begin
						done_r <= 1'b0;
						sda_oe_o <= 1'b1;
						ic_r <= lpsc_pkg::IC_WACK;
						if (!have_ptr_r) begin                // First byte: pointer
							ptr_r <= sh_r;
							have_ptr_r <= 1'b1;
						end else begin                        // Data, auto increment
							wr_stb_r <= 1'b1;
							wr_addr_r <= ptr_r;
							wr_data_r <= sh_r;
							ptr_r <= ptr_r + 8'h01;
						end
					end
					lpsc_pkg::IC_AACK, lpsc_pkg::IC_RACK: begin
						if (ic_r == lpsc_pkg::IC_RACK && done_r) begin
							sda_oe_o <= 1'b0;                   // NACK ends the read
							ic_r <= lpsc_pkg::IC_IDLE;
						end else if (ic_r == lpsc_pkg::IC_AACK && !rw_r) begin
							sda_oe_o <= 1'b0;
							bit_r <= 3'h0;
							ic_r <= lpsc_pkg::IC_WR;
						end else begin                        // Load next read byte
							tx_r <= rd_data;
							sda_oe_o <= !rd_data[7];
							ptr_r <= ptr_r + 8'h01;
							bit_r <= 3'h0;
							ic_r <= lpsc_pkg::IC_RD;
						end
					end
					lpsc_pkg::IC_WACK: begin
						sda_oe_o <= 1'b0;
						bit_r <= 3'h0;
						ic_r <= lpsc_pkg::IC_WR;
					end
					lpsc_pkg::IC_RD: begin
						if (bit_r == 3'h7) begin              // Release for host ack
							sda_oe_o <= 1'b0;
							done_r <= 1'b0;
							ic_r <= lpsc_pkg::IC_RACK;
						end else begin
							tx_r <= {tx_r[6:0], 1'b0};
							sda_oe_o <= !tx_r[6];
							bit_r <= bit_r + 3'h1;
						end
					end
					default: ic_r <= lpsc_pkg::IC_IDLE;    // Code 111 is illegal
				endcase
			end
		end
	end

	// Write decode
	assign wr_cfg = wr_stb_r && (wr_addr_r == lpsc_pkg::REG_CONFIG);
	assign wr_int = wr_stb_r && (wr_addr_r == lpsc_pkg::REG_INTERRUPT);

	// Configuration and threshold registers; unused bits of 0x01 are stored as
	// written, the host is expected to keep them zero
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			cfg_r <= lpsc_pkg::REG_RESET;
			prox_low_r <= lpsc_pkg::REG_RESET;
			prox_high_r <= lpsc_pkg::REG_RESET;
			th1_r <= lpsc_pkg::REG_RESET;
			th2_r <= lpsc_pkg::REG_RESET;
			th3_r <= lpsc_pkg::REG_RESET;
			range_r <= 3'h0;
		end else if (ce_i && wr_stb_r) begin
			if (wr_cfg)
				cfg_r <= wr_data_r;
			if (wr_addr_r == lpsc_pkg::REG_PROX_LOW)
				prox_low_r <= wr_data_r;
			if (wr_addr_r == lpsc_pkg::REG_PROX_HIGH)
				prox_high_r <= wr_data_r;
			if (wr_addr_r == lpsc_pkg::REG_LIGHT_TH1)
				th1_r <= wr_data_r;
			if (wr_addr_r == lpsc_pkg::REG_LIGHT_TH2)
				th2_r <= wr_data_r;
			if (wr_addr_r == lpsc_pkg::REG_LIGHT_TH3)
				th3_r <= wr_data_r;
			if (wr_addr_r == lpsc_pkg::REG_LIGHT_RNG)
				range_r <= wr_data_r[2:0];
		end
	end

	// Window comparison
	assign light_low  = {th2_r[3:0], th1_r};
	assign light_high = {th3_r, th2_r[7:4]};
	assign light_stb  = light_valid_i && cfg_r.light_enable;
	assign light_out  = (light_result_i < light_low) ||
		(light_result_i > light_high);
	assign prox_out   = (prox_result_i < prox_low_r) ||
		(prox_result_i > prox_high_r);
	assign px_done    = (px_r == lpsc_pkg::PX_MEAS) && (px_cnt_r == 25'h0);

	// Light code 00 flags every result, so the window is bypassed there
	lpsc_persist u_light_persist (
		.mclk_i (mclk_i),
		.reset_i(reset_i),
		.ce_i   (ce_i),
		.stb_i  (light_stb),
		.out_i  (light_out || (int_r.light_persistence == 2'b00)),
		.prst_i (int_r.light_persistence),
		.hit_o  (light_hit)
	);

	lpsc_persist u_prox_persist (
		.mclk_i (mclk_i),
		.reset_i(reset_i),
		.ce_i   (ce_i),
		.stb_i  (px_done),
		.out_i  (prox_out),
		.prst_i (int_r.prox_persistence),
		.hit_o  (prox_hit)
	);

	// Interrupt register; a hit in the clearing cycle keeps its flag set
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			int_r <= lpsc_pkg::REG_RESET;
		end else if (ce_i) begin
			if (wr_int) begin
				int_r <= wr_data_r;                  // Flags cleared by 0
				int_r.prox_event_flag <= prox_hit ||
					(int_r.prox_event_flag && wr_data_r[7]);
				int_r.light_event_flag <= light_hit ||
					(int_r.light_event_flag && wr_data_r[3]);
			end else begin
				int_r.prox_event_flag  <= int_r.prox_event_flag || prox_hit;
				int_r.light_event_flag <= int_r.light_event_flag || light_hit;
			end
		end
	end

	// Sleep length from the code; code 111 is zero, i.e. continuous
	assign sleep_cyc = 25'(lpsc_pkg::SLEEP_US[cfg_r.prox_sleep_select] *
		CYC_PER_US);

	// Proximity sequencer: measure, capture, sleep, repeat
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			px_r <= lpsc_pkg::PX_OFF;
			px_cnt_r <= 25'h0;
			prox_data_r <= 8'h00;
		end else if (ce_i) begin
			if (!cfg_r.prox_enable) begin
				px_r <= lpsc_pkg::PX_OFF;
			end else begin
				unique case (px_r)
					lpsc_pkg::PX_OFF: begin
						px_r <= lpsc_pkg::PX_MEAS;
						px_cnt_r <= 25'(MEAS_CYC - 1);
					end
					lpsc_pkg::PX_MEAS: if (px_done) begin
						prox_data_r <= prox_result_i;
						// Code 111 still idles one cycle: pulses stay distinct
						px_r <= lpsc_pkg::PX_SLEEP;
						px_cnt_r <= (sleep_cyc == 25'h0) ? 25'h0 :
							sleep_cyc - 25'h1;
					end else begin
						px_cnt_r <= px_cnt_r - 25'h1;
					end
					lpsc_pkg::PX_SLEEP: if (px_cnt_r == 25'h0) begin
						px_r <= lpsc_pkg::PX_MEAS;
						px_cnt_r <= 25'(MEAS_CYC - 1);
					end else begin
						px_cnt_r <= px_cnt_r - 25'h1;
					end
					default: px_r <= lpsc_pkg::PX_OFF;          // Code 11 is illegal
				endcase
			end
		end
	end

	// Light capture and registered outputs
	assign irq_cond = int_r.combine_and ?
		(int_r.prox_event_flag && int_r.light_event_flag) :
		(int_r.prox_event_flag || int_r.light_event_flag);

	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			light_data_r <= 12'h000;
			irq_out_low_o <= 1'b1;
			power_down_o <= 1'b1;
			light_full_scale_code_o <= 3'h0;
		end else if (ce_i) begin
			if (light_stb)
				light_data_r <= light_result_i;
			irq_out_low_o <= !irq_cond;
			power_down_o <= !cfg_r.prox_enable && !cfg_r.light_enable;
			light_full_scale_code_o <= range_r[2] ? lpsc_pkg::RANGE_50LUX :
				range_r;
		end
	end

	assign light_enable_o         = cfg_r.light_enable;
	assign prox_enable_o          = cfg_r.prox_enable;
	assign emitter_drive_select_o = cfg_r.emitter_drive_select;
	assign emitter_pulse_o        = px_r[0];    // Only the measure code has bit 0
endmodule

// File: sim/lpsc_host.sv
// I2C host model that reaches the sensor control block over its pins.
// Assumes an open-drain data wire that the bench resolves from both ends.
`timescale 1ns/1ps
module lpsc_host (
	output logic      scl_o,     // Bus clock, idles high
	output logic      sda_low_o, // High pulls the data wire low
	input  wire logic sda_i      // Resolved data wire level
);
	localparam int HALF = 100; // Half period of the 200 ns bus clock
	logic nack; // Set when any address or data byte went unanswered

	// Bus idles high; the clock stands still outside frames
	initial begin
		scl_o = 1'b1;
		sda_low_o = 1'b0;
		nack = 1'b0;
	end
	// Start or repeated start: data falls while the clock is high
	task automatic start();
		#(HALF/2) sda_low_o = 1'b0;
		#(HALF/2) scl_o = 1'b1;
		#HALF sda_low_o = 1'b1;
		#HALF scl_o = 1'b0;
	endtask
	// Stop: data rises while the clock is high
	task automatic stop();
		#(HALF/2) sda_low_o = 1'b1;
		#(HALF/2) scl_o = 1'b1;
		#HALF sda_low_o = 1'b0;
		#HALF;
	endtask
	// One bit: data moves mid-low, sampled mid-high so both ends agree
	task automatic bit_io(input logic b, output logic r);
		#(HALF/2) sda_low_o = ~b;
		#(HALF/2) scl_o = 1'b1;
		#(HALF/2) r = sda_i;
		#(HALF/2) scl_o = 1'b0;
	endtask
	// Byte out, MSB first, then the target's acknowledge bit
	task automatic byte_wr(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(d[i], r);
		end
		bit_io(1'b1, r);
		nack = nack | r;
	endtask
	// Byte in; the host answers with a not-acknowledge on the last byte
	task automatic byte_rd(input logic last, output logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) begin
			bit_io(1'b1, d[i]);
		end
		bit_io(last, r);
	endtask
	// Register write: write address byte, pointer, data
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		nack = 1'b0;
		start();
		byte_wr(lpsc_pkg::ADDR_WR_BYTE);
		byte_wr(a);
		byte_wr(d);
		stop();
	endtask
	// Register read: pointer set by a write, then repeated start to read
	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		nack = 1'b0;
		start();
		byte_wr(lpsc_pkg::ADDR_WR_BYTE);
		byte_wr(a);
		start();
		byte_wr(lpsc_pkg::ADDR_RD_BYTE);
		byte_rd(1'b1, d);
		stop();
	endtask
	// Address probe only, to see whether a byte is answered
	task automatic probe(input logic [7:0] a);
		nack = 1'b0;
		start();
		byte_wr(a);
		stop();
	endtask
endmodule

// File: sim/lpsc_checker.sv
// Port-level checks of the sensor control block, bound to lpsc_top.
// Assumes one clock domain, mclk_i, with synchronous active-high reset.
`timescale 1ns/1ps
module lpsc_checker #(
	parameter int MEAS_CYC   = 20, // Measurement length in cycles
	parameter int CYC_PER_US = 1   // Sleep scale, carried for symmetry
) (
	input wire logic       mclk_i,                  // System clock
	input wire logic       reset_i,                 // Synchronous reset
	input wire logic       ce_i,                    // Clock enable
	input wire logic       scl_i,                   // Bus clock pin
	input wire logic       sda_o,                   // Data drive value
	input wire logic       sda_oe_o,                // Data drive enable
	input wire logic       light_enable_o,          // Light active
	input wire logic       prox_enable_o,           // Prox active
	input wire logic       power_down_o,            // Both off
	input wire logic       emitter_pulse_o,         // Measurement window
	input wire logic [2:0] light_full_scale_code_o, // Decoded range
	input wire logic       irq_out_low_o            // Interrupt pin
);
	logic [15:0] pulse_cnt_r; // Cycles the window has stood so far
	logic        scl_q_r;     // Last sampled bus clock
	logic [3:0]  quiet_r;     // Cycles since the bus clock moved

	default clocking @(posedge mclk_i); endclocking
	default disable iff (reset_i);

	// Window length counter, cleared whenever the window is down
	always_ff @(posedge mclk_i) begin
		if (reset_i || !emitter_pulse_o) begin
			pulse_cnt_r <= '0;
		end else if (ce_i) begin
			pulse_cnt_r <= pulse_cnt_r + 16'h0001;
		end
	end
	// Quiet counter: a flag clear can only follow bus clock activity
	always_ff @(posedge mclk_i) begin
		scl_q_r <= scl_i;
		if (reset_i || scl_i != scl_q_r) begin
			quiet_r <= '0;
		end else if (quiet_r != 4'hf) begin
			quiet_r <= quiet_r + 4'h1;
		end
	end

	property p_pwr_on;
		!light_enable_o && !prox_enable_o && ce_i |=> power_down_o;
	endproperty
	a_pwr_on: assert property (p_pwr_on) else $error("power-down missing");
	property p_pwr_off;
		(light_enable_o || prox_enable_o) && ce_i |=> !power_down_o;
	endproperty
	a_pwr_off: assert property (p_pwr_off) else $error("power-down stuck");
	property p_meas_len;
		$fell(emitter_pulse_o) && prox_enable_o |-> int'(pulse_cnt_r) == MEAS_CYC;
	endproperty
	a_meas_len: assert property (p_meas_len) else $error("window length");
	property p_meas_max;
		int'(pulse_cnt_r) <= MEAS_CYC;
	endproperty
	a_meas_max: assert property (p_meas_max) else $error("window too long");
	property p_pulse_en;
		$rose(emitter_pulse_o) |-> prox_enable_o;
	endproperty
	a_pulse_en: assert property (p_pulse_en) else $error("pulse while off");
	property p_sda_zero;
		sda_oe_o |-> !sda_o;
	endproperty
	a_sda_zero: assert property (p_sda_zero) else $error("data not low");
	property p_oe_stands;
		$changed(sda_oe_o) |-> !$past(scl_i, 2);
	endproperty
	a_oe_stands: assert property (p_oe_stands) else $error("data moved high");
	property p_range;
		light_full_scale_code_o <= 3'h4;
	endproperty
	a_range: assert property (p_range) else $error("range code bad");
	property p_irq_holds;
		!irq_out_low_o && quiet_r == 4'hf |=> !irq_out_low_o;
	endproperty
	a_irq_holds: assert property (p_irq_holds) else $error("irq released");
	property p_rst_vals;
		$fell(reset_i) |-> irq_out_low_o && power_down_o && !emitter_pulse_o;
	endproperty
	a_rst_vals: assert property (p_rst_vals) else $error("reset values");
endmodule

bind lpsc_top lpsc_checker #(
	.MEAS_CYC  (MEAS_CYC),
	.CYC_PER_US(CYC_PER_US)
) u_chk (
	.mclk_i                 (mclk_i),
	.reset_i                (reset_i),
	.ce_i                   (ce_i),
	.scl_i                  (scl_i),
	.sda_o                  (sda_o),
	.sda_oe_o               (sda_oe_o),
	.light_enable_o         (light_enable_o),
	.prox_enable_o          (prox_enable_o),
	.power_down_o           (power_down_o),
	.emitter_pulse_o        (emitter_pulse_o),
	.light_full_scale_code_o(light_full_scale_code_o),
	.irq_out_low_o          (irq_out_low_o)
);

// File: sim/lpsc_top_test.sv
// Self-checking bench for lpsc_top, driven through the I2C host model.
// Assumes the shortened timing parameters given to the instance below.
`timescale 1ns/1ps
module lpsc_top_test;
	logic        mclk_i, reset_i, ce_i, scl, host_low, sda_w; // Pins
	logic        sda_o, sda_oe_o, light_valid_i;              // Pins
	logic [11:0] light_result_i;  // Light converter result
	logic [7:0]  prox_result_i;   // Prox converter result
	logic [7:0]  rd;              // Last register value read
	logic        le, pe, pd, drv, pulse, irq_n; // Block outputs
	logic [2:0]  fsc;             // Decoded range
	int          err_count, check_count, gap; // Tallies and gap

	// Open-drain wire: either end may pull it low, else it floats high
	assign sda_w = ~host_low & (sda_oe_o ? sda_o : 1'b1);

	lpsc_host host (.scl_o(scl), .sda_low_o(host_low), .sda_i(sda_w));
	lpsc_top #(.MEAS_CYC(20), .CYC_PER_US(1)) dut (
		.mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i), .scl_i(scl),
		.sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o),
		.light_result_i(light_result_i), .light_valid_i(light_valid_i),
		.prox_result_i(prox_result_i), .light_enable_o(le),
		.prox_enable_o(pe), .power_down_o(pd), .emitter_drive_select_o(drv),
		.emitter_pulse_o(pulse), .light_full_scale_code_o(fsc),
		.irq_out_low_o(irq_n));

	// 40 MHz system clock
	initial begin
		mclk_i = 1'b0;
		forever #12.5 mclk_i = ~mclk_i;
	end
	// Compare one value and tally it
	task automatic check(input string nm, input logic [7:0] seen,
		input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Counts, verdict and end of run
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", check_count, err_count);
		if (err_count == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// One light result strobe, then time for flag and pin to settle
	task automatic light(input logic [11:0] v);
		@(negedge mclk_i);
		light_result_i = v;
		light_valid_i = 1'b1;
		@(negedge mclk_i);
		light_valid_i = 1'b0;
		repeat (3) @(negedge mclk_i);
	endtask
	// Bounded wait for the emitter window to reach a level
	task automatic wait_pulse(input logic lvl, output int n);
		n = 0;
		while (pulse !== lvl) begin
			@(negedge mclk_i);
			n++;
			if (n > 20000) begin
				err_count++;
				$display("[ERR] emitter_pulse_o expected %b seen timeout", lvl);
				end_of_test();
			end
		end
	endtask

	initial begin
		err_count = 0;
		check_count = 0;
		reset_i = 1'b1;
		ce_i = 1'b1;
		light_valid_i = 1'b0;
		light_result_i = 12'h000;
		prox_result_i = 8'h00;
		repeat (20) @(negedge mclk_i);
		reset_i = 1'b0;
		repeat (4) @(negedge mclk_i);
		check("pd_reset", {7'h00, pd}, 8'h01);
		check("irq_reset", {7'h00, irq_n}, 8'h01);
		// Every range code, decoded and read back
		for (int i = 0; i < 8; i++) begin
			host.wr_reg(lpsc_pkg::REG_LIGHT_RNG, 8'(i));
			check("wr_ack", {7'h00, host.nack}, 8'h00);
			check("range", {5'h00, fsc}, (i < 4) ? 8'(i) : 8'h04);
			host.rd_reg(lpsc_pkg::REG_LIGHT_RNG, rd);
			check("range_rd", rd, 8'(i));
		end
		$display("test range done");
		// Upper result nibble and sticky light flag, OR combine
		host.wr_reg(lpsc_pkg::REG_CONFIG, 8'h04);
		check("light_en", {6'h00, le, pd}, 8'h02);
		light(12'habc);
		host.rd_reg(lpsc_pkg::REG_LIGHT_DT2, rd);
		check("result_hi", rd, 8'h0a);
		check("irq_or", {7'h00, irq_n}, 8'h00);
		host.rd_reg(lpsc_pkg::REG_INTERRUPT, rd);
		check("flag_rd", rd, 8'h08);
		host.wr_reg(lpsc_pkg::REG_INTERRUPT, 8'h00);
		check("irq_clr", {7'h00, irq_n}, 8'h01);
		$display("test result done");
		// Window 0x100..0x200, run of four needed, broken twice
		host.wr_reg(lpsc_pkg::REG_LIGHT_TH1, 8'h00);
		host.wr_reg(lpsc_pkg::REG_LIGHT_TH2, 8'h01);
		host.wr_reg(lpsc_pkg::REG_LIGHT_TH3, 8'h20);
		host.wr_reg(lpsc_pkg::REG_INTERRUPT, 8'h02);
		for (int i = 0; i < 7; i++) begin
			light((i inside {0, 3}) ? 12'h150 : 12'h050);
		end
		check("irq_run", {7'h00, irq_n}, 8'h01);
		light(12'h201);
		check("irq_run4", {7'h00, irq_n}, 8'h00);
		$display("test persist done");
		// AND combine: light alone is not enough, prox completes it
		host.wr_reg(lpsc_pkg::REG_INTERRUPT, 8'h01);
		light(12'h123);
		check("irq_and1", {7'h00, irq_n}, 8'h01);
		host.wr_reg(lpsc_pkg::REG_PROX_LOW, 8'h10);
		host.wr_reg(lpsc_pkg::REG_PROX_HIGH, 8'h20);
		prox_result_i = 8'h05;
		host.wr_reg(lpsc_pkg::REG_CONFIG, 8'hfc);
		check("drive_hi", {6'h00, drv, pe}, 8'h03);
		wait_pulse(1'b1, gap);
		wait_pulse(1'b0, gap);
		repeat (3) @(negedge mclk_i);
		check("irq_and2", {7'h00, irq_n}, 8'h00);
		$display("test combine done");
		// Sleep code 110 between measurements, scaled to one cycle per us
		host.wr_reg(lpsc_pkg::REG_CONFIG, 8'he4);
		check("drive_lo", {7'h00, drv}, 8'h00);
		wait_pulse(1'b1, gap);
		wait_pulse(1'b0, gap);
		wait_pulse(1'b1, gap);
		check("sleep", {7'h00, 1'(gap >= 12499 && gap <= 12503)}, 8'h01);
		$display("test sleep done");
		// Power-down, then light results must be ignored
		host.wr_reg(lpsc_pkg::REG_CONFIG, 8'h00);
		check("pd_on", {6'h00, le, pd}, 8'h01);
		host.wr_reg(lpsc_pkg::REG_INTERRUPT, 8'h00);
		light(12'hfff);
		check("irq_off", {7'h00, irq_n}, 8'h01);
		// Foreign address is left unanswered
		host.probe(8'h90);
		check("foreign", {7'h00, host.nack}, 8'h01);
		$display("test power done");
		end_of_test();
	end
endmodule
